// ==== rtl/fcpg_top.sv ====
// Four-channel pulse generator with an APB register slave.
// Assumes an APB master on mclk and external loads on the four pulse outputs.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "fcpg_cfg.svh"

module fcpg_top #(
  parameter int NCH = 4,
  parameter int VW  = 10
) (
  // Clock, reset and freeze.
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              ce,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [19:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Pulse outputs.
  output logic      [NCH-1:0]    pulse_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------

  // The register map holds exactly four ten-bit channels.
  if (NCH != `FCPG_NCH || VW != `FCPG_VAL_W)
  begin : g_bad_param
    $error("fcpg_top supports only four channels of ten bits");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Maps a byte address to a register select code.
  function automatic logic [3:0] fcpg_decode(input logic [19:0] a);
    logic [3:0] s;
    s = `FCPG_SEL_NONE;
    if (a[1:0] == 2'h0)
    begin
      unique case (a[19:2])
        `FCPG_IDX_CTRL:  s = `FCPG_SEL_CTRL;
        `FCPG_IDX_LIMIT: s = `FCPG_SEL_LIMIT;
        `FCPG_IDX_BEG0:  s = 4'h2;
        `FCPG_IDX_END0:  s = 4'h3;
        `FCPG_IDX_BEG1:  s = 4'h4;
        `FCPG_IDX_END1:  s = 4'h5;
        `FCPG_IDX_BEG2:  s = 4'h6;
        `FCPG_IDX_END2:  s = 4'h7;
        `FCPG_IDX_BEG3:  s = 4'h8;
        `FCPG_IDX_END3:  s = 4'h9;
        `FCPG_IDX_COUNT: s = `FCPG_SEL_COUNT;
        default:         s = `FCPG_SEL_NONE;
      endcase
    end
    return s;
  endfunction : fcpg_decode

  // Returns the last prescaler value before a tick for a rate code.
  function automatic logic [`FCPG_PRE_W-1:0] fcpg_div(input logic [2:0] code);
    logic [3:0] sh;
    unique case (code)
      3'h0: sh = `FCPG_SHIFT_0;
      3'h1: sh = `FCPG_SHIFT_1;
      3'h2: sh = `FCPG_SHIFT_2;
      3'h3: sh = `FCPG_SHIFT_3;
      3'h4: sh = `FCPG_SHIFT_4;
      3'h5: sh = `FCPG_SHIFT_5;
      3'h6: sh = `FCPG_SHIFT_6;
      3'h7: sh = `FCPG_SHIFT_7;
    endcase
    return (`FCPG_PRE_W'(1) << sh) - `FCPG_PRE_W'(1);
  endfunction : fcpg_div

  // ----------------------------------------------------------------
  // State and decoded fields
  // ----------------------------------------------------------------

  fcpg_pkg::fcpg_state_t st_r;
  fcpg_pkg::fcpg_state_t st_nxt;
  logic                  run;
  logic                  oneshot;
  logic [NCH-1:0]        pol;
  logic [NCH-1:0]        en;
  logic                  tick;
  logic                  wrap;
  logic                  wr_en;
  logic [3:0]            sel;
  logic [NCH-1:0]        act;

  // Control fields and bus strobes.
  assign run     = st_r.ctrl[`FCPG_RUN_BIT];
  assign oneshot = st_r.ctrl[`FCPG_MODE_BIT];
  assign pol     = st_r.ctrl[`FCPG_POL_HI:`FCPG_POL_LO];
  assign en      = st_r.ctrl[`FCPG_EN_HI:`FCPG_EN_LO];
  assign sel     = fcpg_decode(paddr);
  assign wr_en   = psel && penable && pwrite && (st_r.bus == fcpg_pkg::BUS_DONE) && (sel != `FCPG_SEL_NONE);

  // Tick and end of window.
  // tick rate select
  assign tick = run && (st_r.presc == fcpg_div(st_r.ctrl[`FCPG_RATE_HI:`FCPG_RATE_LO]));
  assign wrap = tick && (st_r.win == st_r.limit);

  // Per-channel active window.
  for (genvar c = 0; c < NCH; c++)
  begin : g_chan
    always_comb
    begin
      if (st_r.beg[c] == st_r.fin[c])
        act[c] = 1'b0;
      else if (st_r.fin[c] > st_r.limit)
        act[c] = 1'b1;
      else
        act[c] = (st_r.win >= st_r.beg[c]) && (st_r.win < st_r.fin[c]);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Counter, one-shot tracking, outputs and the register slave.
  always_comb
  begin
    st_nxt = st_r;
    if (!run)
    begin
      st_nxt.presc = '0;
      st_nxt.win   = '0;
      st_nxt.done  = '0;
    end
    else if (!tick)
      st_nxt.presc = st_r.presc + `FCPG_PRE_W'(1);
    else
    begin
      st_nxt.presc = '0;
      st_nxt.win = wrap ? '0 : st_r.win + `FCPG_VAL_W'(1);
      if (wrap && oneshot)
      begin
        if (st_r.done == st_r.cycles)
        begin
          st_nxt.ctrl[`FCPG_RUN_BIT] = 1'b0;
          st_nxt.done                = '0;
        end
        else
          st_nxt.done = st_r.done + `FCPG_VAL_W'(1);
      end
    end
    st_nxt.pulse = (run ? (act & en) : '0) ~^ pol;
    // Bus answer: one wait state, then the write lands with pready high.
    unique case (st_r.bus)
      fcpg_pkg::BUS_IDLE:
      begin
        if (psel && penable)
        begin
          st_nxt.bus   = fcpg_pkg::BUS_DONE;
          st_nxt.err   = (sel == `FCPG_SEL_NONE);
          st_nxt.rdata = '0;
          if (sel == `FCPG_SEL_CTRL)
            st_nxt.rdata[15:0] = st_r.ctrl;
          else if (sel == `FCPG_SEL_LIMIT)
            st_nxt.rdata[VW-1:0] = st_r.limit;
          else if (sel == `FCPG_SEL_COUNT)
            st_nxt.rdata[VW-1:0] = st_r.cycles;
          else if (sel != `FCPG_SEL_NONE)
            st_nxt.rdata[VW-1:0] = sel[0] ? st_r.fin[(sel - `FCPG_SEL_BEG0) >> 1]
                                          : st_r.beg[(sel - `FCPG_SEL_BEG0) >> 1];
        end
      end
      fcpg_pkg::BUS_DONE:
      begin
        st_nxt.bus = fcpg_pkg::BUS_IDLE;
        st_nxt.err = 1'b0;
      end
    endcase
    // A software write comes last, so a write that sets run wins over a self halt.
    if (wr_en)
    begin
      if (sel == `FCPG_SEL_CTRL)
        st_nxt.ctrl = pwdata[15:0] & `FCPG_CTRL_MASK;
      else if (sel == `FCPG_SEL_LIMIT)
        st_nxt.limit = pwdata[VW-1:0];
      else if (sel == `FCPG_SEL_COUNT)
        st_nxt.cycles = pwdata[VW-1:0];
      else if (sel[0])
        st_nxt.fin[(sel - `FCPG_SEL_BEG0) >> 1] = pwdata[VW-1:0];
      else
        st_nxt.beg[(sel - `FCPG_SEL_BEG0) >> 1] = pwdata[VW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Synchronous reset; a low clock enable freezes everything.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_r        <= '0;
      st_r.ctrl   <= `FCPG_CTRL_RESET;
      st_r.limit  <= `FCPG_LIMIT_RESET;
      st_r.bus    <= fcpg_pkg::BUS_IDLE;
    end
    else if (ce)
      st_r <= st_nxt;
  end

  // Outputs straight from the state.
  assign prdata  = st_r.rdata;
  assign pready  = (st_r.bus == fcpg_pkg::BUS_DONE);
  assign pslverr = st_r.err;
  assign pulse_o = st_r.pulse;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  // Channel checks watch channel 0; the other channels share the same generated logic.
  a_reset_zero: assert property (@(posedge mclk) !rstn |=> (st_r.ctrl == '0) && (st_r.limit == '0))
    else $error("control or limit not zero after reset");

  a_stop_rest: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && !run) |=> (st_r.win == '0) && (st_r.presc == '0))
    else $error("counter moved while stopped");

  a_tick_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && run && !tick && !wr_en) |=> (st_r.win == $past(st_r.win)) && (st_r.presc == $past(st_r.presc) + 1'b1))
    else $error("counter stepped without a tick");

  a_window_wrap: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && wrap) |=> (st_r.win == '0))
    else $error("counter did not wrap at the limit");

  a_oneshot_halt: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && wrap && oneshot && (st_r.done == st_r.cycles) && !wr_en) |=> !run)
    else $error("one-shot did not halt");

  a_count_more: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && wrap && oneshot && (st_r.done != st_r.cycles) && !wr_en) |=> run && (st_r.done == $past(st_r.done) + 1'b1))
    else $error("one-shot halted before its last cycle");

  a_cont_keeps: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && run && !oneshot && !wr_en) |=> run)
    else $error("continuous mode halted by itself");

  a_limit_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && run && (st_r.win <= st_r.limit) && !wr_en) |=> (st_r.win <= st_r.limit))
    else $error("counter ran past the window limit");

  a_out_idle: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && (!run || en == '0)) |=> (pulse_o == ~$past(pol)))
    else $error("output active while stopped or disabled");

  a_begin_on: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && run && en[0] && (st_r.beg[0] < st_r.fin[0]) && (st_r.fin[0] <= st_r.limit)
      && (st_r.win == st_r.beg[0])) |=> (pulse_o[0] == $past(pol[0])))
    else $error("pulse not active at its begin position");

  a_end_off: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && run && en[0] && (st_r.beg[0] < st_r.fin[0]) && (st_r.fin[0] <= st_r.limit)
      && (st_r.win == st_r.fin[0])) |=> (pulse_o[0] == ~$past(pol[0])))
    else $error("pulse still active at its end position");

  a_low_active: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && run && en[0] && !pol[0] && (st_r.beg[0] < st_r.fin[0]) && (st_r.fin[0] <= st_r.limit)
      && (st_r.win == st_r.beg[0])) |=> (pulse_o[0] == 1'b0))
    else $error("active-low channel did not drive low");

  a_equal_off: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && (st_r.beg[0] == st_r.fin[0])) |=> (pulse_o[0] == ~$past(pol[0])))
    else $error("equal begin and end gave an active pulse");

  a_beyond_on: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && run && en[0] && (st_r.fin[0] > st_r.limit) && (st_r.beg[0] != st_r.fin[0]))
      |=> (pulse_o[0] == $past(pol[0])))
    else $error("end beyond limit did not hold the pulse active");

  a_bus_answer: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && psel && penable && !pready) |=> pready)
    else $error("bus answer not given after one wait state");

endmodule : fcpg_top

// ==== rtl/fcpg_cfg.svh ====
// Constants of the four-channel pulse generator: register indices, fields, reset values, tick ratios.
// Assumes inclusion by the package, the top module and the bench, by bare name.
//
// Contract
// - Run bit set starts all pulse generation; run bit clear stops it.
// - Three-bit tick-rate field picks one of eight counter tick rates.
// - One-shot mode runs the programmed cycles, then clears run by itself.
// - Continuous mode wraps the counter at the window limit and never halts.
// - Per-channel polarity bits 7..4; one means active high, zero active low.
// - Per-channel enable bits 3..0; a channel pulses only while enabled.
// - Ten-bit window limit sets every channel's cycle length in ticks.
// - Control and window limit read zero after reset.
// - Ten-bit begin value is the counter position where the pulse starts.
// - Ten-bit end value stops the pulse; begin equal to end keeps it inactive.
// - End value above the window limit keeps the output continuously active while begin differs from end.
// - One-shot runs cycle-count plus one cycles.
`ifndef FCPG_CFG_SVH
`define FCPG_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define FCPG_IDX_CTRL     18'h0c0e6
`define FCPG_IDX_LIMIT    18'h0c0e8
`define FCPG_IDX_BEG0     18'h0c0ea
`define FCPG_IDX_END0     18'h0c0ec
`define FCPG_IDX_BEG1     18'h0c0ee
`define FCPG_IDX_END1     18'h0c0f0
`define FCPG_IDX_BEG2     18'h0c0f2
`define FCPG_IDX_END2     18'h0c0f4
`define FCPG_IDX_BEG3     18'h0c0f6
`define FCPG_IDX_END3     18'h0c0f8
`define FCPG_IDX_COUNT    18'h0c0fa

// Register select codes returned by the address decoder.
`define FCPG_SEL_CTRL     4'h0
`define FCPG_SEL_LIMIT    4'h1
`define FCPG_SEL_BEG0     4'h2
`define FCPG_SEL_COUNT    4'ha
`define FCPG_SEL_NONE     4'hf

// Control register fields.
`define FCPG_RUN_BIT      15
`define FCPG_RATE_HI      11
`define FCPG_RATE_LO      9
`define FCPG_MODE_BIT     8
`define FCPG_POL_HI       7
`define FCPG_POL_LO       4
`define FCPG_EN_HI        3
`define FCPG_EN_LO        0
`define FCPG_CTRL_MASK    16'h8fff
`define FCPG_CTRL_RESET   16'h0000
`define FCPG_LIMIT_RESET  10'h000

// Widths.
`define FCPG_VAL_W        10
`define FCPG_PRE_W        13
`define FCPG_NCH          4

// Tick divide ratios as powers of two of the fastest rate, codes 000 to 111.
`define FCPG_SHIFT_0      4'h0
`define FCPG_SHIFT_1      4'h1
`define FCPG_SHIFT_2      4'h3
`define FCPG_SHIFT_3      4'h5
`define FCPG_SHIFT_4      4'h7
`define FCPG_SHIFT_5      4'h9
`define FCPG_SHIFT_6      4'hb
`define FCPG_SHIFT_7      4'hd

`endif

// ==== rtl/fcpg_pkg.sv ====
// Types of the four-channel pulse generator.
// Assumes the constants header sits beside it.
`include "fcpg_cfg.svh"

package fcpg_pkg;

  // Bus answer phase.
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } fcpg_bus_t;

  // Whole state of the generator.
  typedef struct packed {
    logic [15:0]                                ctrl;
    logic [`FCPG_VAL_W-1:0]                     limit;
    logic [`FCPG_NCH-1:0][`FCPG_VAL_W-1:0]      beg;
    logic [`FCPG_NCH-1:0][`FCPG_VAL_W-1:0]      fin;
    logic [`FCPG_VAL_W-1:0]                     cycles;
    logic [`FCPG_PRE_W-1:0]                     presc;
    logic [`FCPG_VAL_W-1:0]                     win;
    logic [`FCPG_VAL_W-1:0]                     done;
    logic [`FCPG_NCH-1:0]                       pulse;
    fcpg_bus_t                                  bus;
    logic                                       err;
    logic [31:0]                                rdata;
  } fcpg_state_t;

endpackage : fcpg_pkg

// ==== dv/fcpg_load.sv ====
// Load model on the four pulse outputs: counts high samples of each channel.
// Assumes the bench pulses clr before a span and holds meas high across it.
`timescale 1ns/1ns

module fcpg_load (
  // Clock and measurement control.
  input  wire logic             mclk,
  input  wire logic             clr,
  input  wire logic             meas,
  // Observed outputs and tallies.
  input  wire logic [3:0]       pulse_i,
  output logic      [3:0][15:0] cnt
);
  // Add one per edge for every high channel while measuring.
  always_ff @(posedge mclk)
  begin
    for (int c = 0; c < 4; c++)
    begin
      if (clr)
        cnt[c] <= 16'h0000;
      else if (meas && pulse_i[c])
        cnt[c] <= cnt[c] + 16'h0001;
    end
  end
endmodule : fcpg_load

// ==== dv/tb_four_channel_pulse_generator.sv ====
// Self-checking bench of the pulse generator: APB tasks plus a counting load.
// Assumes the design answers APB with one wait state and ce held high.
`timescale 1ns/1ns
`include "fcpg_cfg.svh"

module tb_four_channel_pulse_generator;
  logic             mclk, rstn, ce, psel, penable, pwrite, clr, meas, pready, pslverr;
  logic [19:0]      paddr;
  logic [31:0]      pwdata, prdata;
  logic [3:0]       pulse_o;
  logic [3:0][15:0] cnt;
  int               n_errors, n_checks;

  fcpg_top dut_u (.mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_o(pulse_o));
  fcpg_load load_u (.mclk(mclk), .clr(clr), .meas(meas), .pulse_i(pulse_o), .cnt(cnt));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  // Compares one value and reports a difference.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
  begin
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  end
  endtask : apb

  task automatic wr(input logic [17:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
  begin
    apb(1'b1, idx, d, q, e);
  end
  endtask : wr

  // Reads a register and compares data and error flag.
  task automatic rd(input logic [17:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic        e;
  begin
    apb(1'b0, idx, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  end
  endtask : rd

  // Counts high samples of every channel over n edges.
  task automatic ms(input int n);
  begin
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr  <= 1'b0;
    meas <= 1'b1;
    repeat (n) @(posedge mclk);
    meas <= 1'b0;
    @(posedge mclk);
  end
  endtask : ms

  task automatic results;
  begin
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask : results

  // --------------------------------------------------------------------
  // Clock, watchdog and tests
  // --------------------------------------------------------------------
  // Free-running 10 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Cuts a hang short well after the tests should end.
  initial
  begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    results();
  end

  // Sequence of register accesses and output measurements.
  initial
  begin
    n_errors = 0; n_checks = 0;
    rstn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 20'h0; pwdata = 32'h0; clr = 1'b0; meas = 1'b0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({28'h0, pulse_o}, 32'hf);                         // idle outputs high
    rd(`FCPG_IDX_CTRL, 32'h0, 1'b0);                      // control resets
    rd(`FCPG_IDX_LIMIT, 32'h0, 1'b0);                     // limit resets
    // reserved bits zero, configured while stopped
    wr(`FCPG_IDX_LIMIT, 32'h0000_03ff);
    rd(`FCPG_IDX_LIMIT, 32'h3ff, 1'b0);                   // ten-bit limit
    rd(18'h0c0e7, 32'h0, 1'b1);                           // unmapped word
    // Five windows of ten ticks; ch1 empty, ch2 past limit, ch3 disabled.
    wr(`FCPG_IDX_LIMIT, 32'h9);
    wr(`FCPG_IDX_BEG0, 32'h2); wr(`FCPG_IDX_END0, 32'h5);
    wr(`FCPG_IDX_BEG0 + 18'h4, 32'h4); wr(`FCPG_IDX_END1, 32'h4);
    wr(`FCPG_IDX_BEG2, 32'h0); wr(`FCPG_IDX_END2, 32'hc);
    wr(`FCPG_IDX_CTRL, 32'h8077);
    rd(`FCPG_IDX_CTRL, 32'h8077, 1'b0);                   // run bit held
    ms(50);
    chk({16'h0, cnt[0]}, 32'd15);                         // begin to end
    chk({16'h0, cnt[1]}, 32'd0);                          // equal bounds
    chk({16'h0, cnt[2]}, 32'd50);                         // end beyond limit
    chk({16'h0, cnt[3]}, 32'd50);                         // disabled inactive
    wr(`FCPG_IDX_CTRL, 32'h8067);
    ms(50);
    chk({16'h0, cnt[0]}, 32'd35);                         // active low
    // Every tick-rate code, two-tick window, ch0 active one tick.
    wr(`FCPG_IDX_CTRL, 32'h0011);
    wr(`FCPG_IDX_LIMIT, 32'h1);
    wr(`FCPG_IDX_BEG0, 32'h0); wr(`FCPG_IDX_END0, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
      automatic int s = (k == 0) ? 0 : 2 * k - 1;
      wr(`FCPG_IDX_CTRL, 32'h8011 | (k << 9));
      repeat (2 << s) @(posedge mclk);
      ms(2 << s);
      chk({16'h0, cnt[0]}, 32'h1 << s);                   // tick rate
    end
    // One-shot of two windows, then self halt.
    wr(`FCPG_IDX_CTRL, 32'h0011);
    ms(4);
    chk({16'h0, cnt[0]}, 32'd0);                          // stopped
    wr(`FCPG_IDX_LIMIT, 32'h9);
    wr(`FCPG_IDX_BEG0, 32'h2); wr(`FCPG_IDX_END0, 32'h5);
    wr(`FCPG_IDX_COUNT, 32'h1);
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr  <= 1'b0;
    meas <= 1'b1;
    wr(`FCPG_IDX_CTRL, 32'h8111);
    rd(`FCPG_IDX_CTRL, 32'h8111, 1'b0);                   // still running
    repeat (40) @(posedge mclk);
    rd(`FCPG_IDX_CTRL, 32'h0111, 1'b0);                   // self halt
    meas <= 1'b0;
    @(posedge mclk);
    chk({16'h0, cnt[0]}, 32'd6);                          // count plus one
    results();
  end
endmodule : tb_four_channel_pulse_generator
